// File: logic/drf_dram_core.sv
/*
 command side of a synchronous dram: burst length on the fly, write byte
 masking, periodic and internal self refresh, locked-loop state, and an
 ahb-lite register slave. all memory pins, including the link clock ck,
 are sampled by clk through two flip-flops; ck must be slow against clk.
*/
`timescale 1ns/1ps
module drf_dram_core (
   input wire logic clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic ck,
   input wire logic cke,
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic resetN,
   input wire logic termCtrlPin,
   input wire logic [13:0] addr,
   input wire logic [2:0] ba,
   input wire logic [15:0] dq,
   input wire logic [1:0] writeByteMask,
   output logic [15:0] rdData,
   output logic rdValid,
   output logic selfRefresh,
   output logic dllLocked
);
   localparam int PIN_W = 8 + drf_pkg::ADDR_W + drf_pkg::BANK_W + drf_pkg::DQ_W + drf_pkg::MASK_W;

   function automatic drf_pkg::drf_cmd_e decodeCmd(input logic c, r, a, w, e);
      if (c) return drf_pkg::CMD_DESEL;
      unique case ({r, a, w})
         3'h7: return drf_pkg::CMD_NOP;
         3'h3: return drf_pkg::CMD_ACT;
         3'h2: return drf_pkg::CMD_PRE;
         // [RQ6] refresh decode
         3'h1: return e ? drf_pkg::CMD_REF : drf_pkg::CMD_SRE;
         3'h5: return drf_pkg::CMD_RD;
         3'h4: return drf_pkg::CMD_WR;
         3'h0: return drf_pkg::CMD_MRS;
         default: return drf_pkg::CMD_OTHER;
      endcase
   endfunction

   logic [PIN_W-1:0] pinMeta_q;
   logic [PIN_W-1:0] pinSync_q;
   logic ckPrev_q;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         pinMeta_q <= '0;
         pinSync_q <= '0;
         ckPrev_q <= 1'b0;
      end else begin
         pinMeta_q <= {ck, cke, csN, rasN, casN, weN, resetN, termCtrlPin, addr, ba, dq, writeByteMask};
         pinSync_q <= pinMeta_q;
         ckPrev_q <= pinSync_q[PIN_W-1];
      end
   end

   logic sCk, sCke, sCsN, sRasN, sCasN, sWeN, sResetN, sTerm;
   logic [13:0] sAddr;
   logic [2:0] sBa;
   logic [15:0] sDq;
   logic [1:0] sMask;
   assign {sCk, sCke, sCsN, sRasN, sCasN, sWeN, sResetN, sTerm, sAddr, sBa, sDq, sMask} = pinSync_q;

   logic ctrlLoopOff_q, ctrlLoopOff_d;
   logic wrPend_q, wrPend_d;
   logic [7:0] wrOfs_q, wrOfs_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic selfRef_q, selfRef_d;
   logic locked_q, locked_d;
   logic [9:0] lockCnt_q, lockCnt_d;
   logic [8:0] srTimer_q, srTimer_d;
   logic [3:0] refBusy_q, refBusy_d;
   logic [12:0] row_q, row_d;
   logic [15:0] refCount_q, refCount_d;
   logic [7:0] bankOpen_q, bankOpen_d;
   drf_pkg::drf_burst_e burst_q, burst_d;
   logic [3:0] beatsLeft_q, beatsLeft_d;
   logic [3:0] col_q, col_d;
   logic chop_q, chop_d;
   logic [15:0] rdData_q, rdData_d;
   logic rdValid_q, rdValid_d;
   logic [15:0] mem_q [drf_pkg::MEM_DEPTH];
   logic [15:0] mem_d [drf_pkg::MEM_DEPTH];

   always_comb begin
      drf_pkg::drf_cmd_e cmd;
      logic addrPhase;
      logic ckRise;
      cmd = decodeCmd(sCsN, sRasN, sCasN, sWeN, sCke);
      addrPhase = hsel & htrans[1] & hready;
      ckRise = sCk & ~ckPrev_q;
      ctrlLoopOff_d = ctrlLoopOff_q;
      wrPend_d = addrPhase & hwrite;
      wrOfs_d = haddr[7:0];
      hrdata_d = 32'h0;
      selfRef_d = selfRef_q;
      locked_d = locked_q;
      lockCnt_d = lockCnt_q;
      srTimer_d = srTimer_q;
      refBusy_d = refBusy_q;
      row_d = row_q;
      refCount_d = refCount_q;
      bankOpen_d = bankOpen_q;
      burst_d = burst_q;
      beatsLeft_d = beatsLeft_q;
      col_d = col_q;
      chop_d = chop_q;
      rdData_d = rdData_q;
      rdValid_d = 1'b0;
      mem_d = mem_q;

      // register slave: read data latched in the address phase
      if (addrPhase && !hwrite) begin
         unique case (haddr[7:0])
            drf_pkg::OFS_CTRL: hrdata_d[drf_pkg::CTRL_LOOP_OFF_BIT] = ctrlLoopOff_q;
            drf_pkg::OFS_STATUS: begin
               hrdata_d[drf_pkg::ST_SELF_REF_BIT] = selfRef_q;
               hrdata_d[drf_pkg::ST_LOCKED_BIT] = locked_q;
               hrdata_d[drf_pkg::ST_REF_BUSY_BIT] = refBusy_q != 4'h0;
               hrdata_d[drf_pkg::ST_CHOP_BIT] = chop_q;
               // termination is off in self-refresh whatever the pin says
               hrdata_d[drf_pkg::ST_TERM_BIT] = sTerm & ~selfRef_q;
               hrdata_d[drf_pkg::ST_BANKS_LSB +: 8] = bankOpen_q;
            end
            drf_pkg::OFS_REFRESH: begin
               hrdata_d[drf_pkg::RF_ROW_LSB +: 13] = row_q;
               hrdata_d[drf_pkg::RF_COUNT_LSB +: 16] = refCount_q;
            end
            default: hrdata_d = 32'h0;
         endcase
      end
      if (wrPend_q && wrOfs_q == drf_pkg::OFS_CTRL) begin
         ctrlLoopOff_d = hwdata[drf_pkg::CTRL_LOOP_OFF_BIT];
      end

      // relock countdown after a loop reset
      if (lockCnt_q != 10'h0) begin
         lockCnt_d = lockCnt_q - 10'h1;
         if (lockCnt_q == 10'h1) begin
            locked_d = 1'b1;
         end
      end

      if (refBusy_q != 4'h0) begin
         refBusy_d = refBusy_q - 4'h1;
         // [RQ9] banks idle after refresh
         if (refBusy_q == 4'h1) begin
            bankOpen_d = 8'h0;
         end
      end

      if (!sResetN) begin
         selfRef_d = 1'b0;
         bankOpen_d = 8'h0;
         burst_d = drf_pkg::BST_IDLE;
         beatsLeft_d = 4'h0;
         refBusy_d = 4'h0;
      end else if (selfRef_q) begin
         // [RQ17] internal timer refresh; command pins and ck unused
         if (srTimer_q == 9'h0) begin
            srTimer_d = 9'(drf_pkg::AVG_INTERVAL_CYC - 1);
            row_d = row_q + 13'h1;
            refCount_d = refCount_q + 16'h1;
         end else begin
            srTimer_d = srTimer_q - 9'h1;
         end
         // [RQ16] exit relocks the loop
         if (sCke) begin
            selfRef_d = 1'b0;
            if (!ctrlLoopOff_q) begin
               lockCnt_d = 10'(drf_pkg::LOOP_LOCK_CYC);
            end
         end
      end else if (ckRise) begin
         if (burst_q != drf_pkg::BST_IDLE) begin
            if (burst_q == drf_pkg::BST_WRITE) begin
               // [RQ4] byte lanes masked; [RQ3] bad timing only hits this word
               for (int i = 0; i < drf_pkg::MASK_W; i++) begin
                  if (!sMask[i]) begin
                     mem_d[col_q][8*i +: 8] = sDq[8*i +: 8];
                  end
               end
            end else begin
               // [RQ5] mask not consulted on reads
               rdData_d = mem_q[col_q];
               rdValid_d = 1'b1;
            end
            col_d = col_q + 4'h1;
            beatsLeft_d = beatsLeft_q - 4'h1;
            if (beatsLeft_q == 4'h1) begin
               burst_d = drf_pkg::BST_IDLE;
            end
         end
         unique case (cmd)
            drf_pkg::CMD_ACT: bankOpen_d[sBa] = 1'b1;
            drf_pkg::CMD_PRE: begin
               if (sAddr[drf_pkg::PRE_ALL_BIT]) begin
                  bankOpen_d = 8'h0;
               end else begin
                  bankOpen_d[sBa] = 1'b0;
               end
            end
            // [RQ8] internal row counter, address ignored
            drf_pkg::CMD_REF: begin
               refBusy_d = 4'(drf_pkg::REFRESH_CYC);
               row_d = row_q + 13'h1;
               refCount_d = refCount_q + 16'h1;
            end
            // [RQ14] entry with enable low
            drf_pkg::CMD_SRE: begin
               selfRef_d = 1'b1;
               srTimer_d = 9'(drf_pkg::SR_FIRST_CYC - 1);
               burst_d = drf_pkg::BST_IDLE;
               beatsLeft_d = 4'h0;
               // [RQ16] loop off on entry
               if (!ctrlLoopOff_q) begin
                  locked_d = 1'b0;
                  lockCnt_d = 10'h0;
               end
            end
            drf_pkg::CMD_RD, drf_pkg::CMD_WR: begin
               burst_d = cmd == drf_pkg::CMD_RD ? drf_pkg::BST_READ : drf_pkg::BST_WRITE;
               // [RQ1] burst length per command
               chop_d = ~sAddr[drf_pkg::BURST_BIT];
               beatsLeft_d = sAddr[drf_pkg::BURST_BIT] ? 4'(drf_pkg::BEATS_FULL) : 4'(drf_pkg::BEATS_CHOP);
               // [RQ2] column from low bits only
               col_d = sAddr[drf_pkg::COL_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrlLoopOff_q <= drf_pkg::CTRL_LOOP_OFF_RST;
         wrPend_q <= 1'b0;
         wrOfs_q <= 8'h0;
         hrdata_q <= 32'h0;
         selfRef_q <= 1'b0;
         locked_q <= drf_pkg::LOCKED_RST;
         lockCnt_q <= 10'h0;
         srTimer_q <= 9'h0;
         refBusy_q <= 4'h0;
         row_q <= 13'h0;
         refCount_q <= 16'h0;
         bankOpen_q <= 8'h0;
         burst_q <= drf_pkg::BST_IDLE;
         beatsLeft_q <= 4'h0;
         col_q <= 4'h0;
         chop_q <= 1'b0;
         rdData_q <= 16'h0;
         rdValid_q <= 1'b0;
         for (int i = 0; i < drf_pkg::MEM_DEPTH; i++) begin
            mem_q[i] <= 16'h0;
         end
      end else begin
         ctrlLoopOff_q <= ctrlLoopOff_d;
         wrPend_q <= wrPend_d;
         wrOfs_q <= wrOfs_d;
         hrdata_q <= hrdata_d;
         selfRef_q <= selfRef_d;
         locked_q <= locked_d;
         lockCnt_q <= lockCnt_d;
         srTimer_q <= srTimer_d;
         refBusy_q <= refBusy_d;
         row_q <= row_d;
         refCount_q <= refCount_d;
         bankOpen_q <= bankOpen_d;
         burst_q <= burst_d;
         beatsLeft_q <= beatsLeft_d;
         col_q <= col_d;
         chop_q <= chop_d;
         rdData_q <= rdData_d;
         rdValid_q <= rdValid_d;
         mem_q <= mem_d;
      end
   end

   // zero wait state slave, always okay; hsize unused, word access only
   logic hreadyout_q;
   logic hresp_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         hreadyout_q <= 1'b0;
         hresp_q <= 1'b0;
      end else begin
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   assign hreadyout = hreadyout_q;
   assign hresp = hresp_q;
   assign hrdata = hrdata_q;
   assign rdData = rdData_q;
   assign rdValid = rdValid_q;
   assign selfRefresh = selfRef_q;
   assign dllLocked = locked_q;
endmodule // drf_dram_core

// File: logic/drf_pkg.sv
/*
 package of constants for the dram command core: register map, field
 positions, reset values, timing counts and command/burst enums.
 assumes a 50 MHz core clock that samples every memory pin.
*/
// Summary of operation
// [RQ1] A12 low picks the four-beat chopped burst, high the eight-beat burst.
// [RQ2] A12 steers burst length only; never part of the column address.
// [RQ3] bad strobe timing may corrupt that write's words only, nothing else.
// [RQ4] one write byte mask bit per eight data lines, sampled like data.
// [RQ5] write byte mask is ignored during reads.
// [RQ6] refresh decodes on CS, RAS, CAS low, WE high; one per refresh.
// [RQ7] controller precharges all banks for row precharge time before refresh.
// [RQ8] refresh row comes from an internal counter; address pins are ignored.
// [RQ9] after a refresh cycle all banks are precharged and idle.
// [RQ10] only no-operation or deselect until refresh cycle time elapses.
// [RQ11] refreshes average one per interval; at most eight postponed.
// [RQ12] at most eight refreshes pulled in; extra ones earn no credit.
// [RQ13] controller clears postponed refreshes before self-refresh entry.
// [RQ14] self-refresh entry is refresh decode with clock enable low; stay low.
// [RQ15] controller precharges and turns termination off before entry.
// [RQ16] loop enabled by mode A0 zero: off on entry, reset and relock on exit; core uses CTRL bit 0 instead.
// [RQ17] in self-refresh only clock enable and reset count; refresh internally.
// [RQ18] controller holds self-refresh the minimum pulse; clock stable before exit.
// [RQ19] exit is clock enable high with no-op; commands wait exit delays.
// [RQ20] controller sends no-ops during exit delay, keeps enable high, termination off.
// [RQ21] controller waits exit delay and issues one extra refresh before re-entry.
// [RQ22] impedance calibration after exit may be needed; advisory.
// [RQ23] controller keeps a refresh debt counter bounded between minus and plus eight.
package drf_pkg;
   localparam int CLK_NS = 20;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_REFRESH = 8'h08;
   localparam int CTRL_LOOP_OFF_BIT = 0;
   localparam logic CTRL_LOOP_OFF_RST = 1'h0;
   localparam int ST_SELF_REF_BIT = 0;
   localparam int ST_LOCKED_BIT = 1;
   localparam int ST_REF_BUSY_BIT = 2;
   localparam int ST_CHOP_BIT = 3;
   localparam int ST_TERM_BIT = 4;
   localparam int ST_BANKS_LSB = 8;
   localparam int RF_ROW_LSB = 0;
   localparam int RF_COUNT_LSB = 16;
   localparam logic LOCKED_RST = 1'h1;
   localparam int REFRESH_CYCLE_NS = 110;
   localparam int REFRESH_CYC = (REFRESH_CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int AVG_INTERVAL_NS = 7800;
   localparam int AVG_INTERVAL_CYC = AVG_INTERVAL_NS / CLK_NS;
   localparam int MIN_CKE_PULSE_NS = 5;
   localparam int SR_FIRST_CYC = (MIN_CKE_PULSE_NS / CLK_NS) < 1 ? 1 : MIN_CKE_PULSE_NS / CLK_NS;
   localparam int LOOP_LOCK_CYC = 512;
   localparam int BEATS_CHOP = 4;
   localparam int BEATS_FULL = 8;
   localparam int ADDR_W = 14;
   localparam int BANK_W = 3;
   localparam int BANKS = 8;
   localparam int DQ_W = 16;
   localparam int MASK_W = DQ_W / 8;
   localparam int COL_W = 4;
   localparam int MEM_DEPTH = 16;
   localparam int ROW_W = 13;
   localparam int BURST_BIT = 12;
   localparam int PRE_ALL_BIT = 10;
   typedef enum logic [3:0] {
      CMD_DESEL = 4'h0, CMD_NOP = 4'h1, CMD_ACT = 4'h2, CMD_PRE = 4'h3, CMD_REF = 4'h4,
      CMD_SRE = 4'h5, CMD_RD = 4'h6, CMD_WR = 4'h7, CMD_MRS = 4'h8, CMD_OTHER = 4'h9
   } drf_cmd_e;
   typedef enum logic [1:0] {
      BST_IDLE = 2'h0, BST_WRITE = 2'h1, BST_READ = 2'h2
   } drf_burst_e;
endpackage

// File: testbench/drf_chk.sv
/*
 port checker for the dram command core.
 assumes one clk domain with rstn synchronous and active low.
*/
`timescale 1ns/1ps
module drf_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   input wire logic cke,
   input wire logic resetN,
   input wire logic rdValid,
   input wire logic selfRefresh,
   input wire logic dllLocked
);
   logic [9:0] lockCnt_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence sSrExit;
      $fell(selfRefresh) ##1 !dllLocked;
   endsequence
   sequence sSrHeld;
      (!cke && resetN && selfRefresh) [*4];
   endsequence
   // saturates so a loop kept off never wraps
   always_ff @(posedge clk) begin
      if (!rstn || selfRefresh || dllLocked) lockCnt_q <= 10'h000;
      else if (lockCnt_q != 10'h3ff) lockCnt_q <= lockCnt_q + 10'h001;
   end
   AST_HRESP: assert property (hresp == 1'b0) else $error("response not okay");
   AST_HREADY: assert property ($past(rstn) |-> hreadyout) else $error("wait state seen");
   AST_RD_IDLE: assert property (!$past(hsel && htrans[1] && !hwrite && hready) |-> hrdata == 32'h0)
      else $error("read data outside data phase");
   AST_BEAT_GAP: assert property (rdValid |=> !rdValid [*6]) else $error("beats too close");
   AST_SR_QUIET: assert property (selfRefresh |-> !rdValid) else $error("beat in self refresh");
   AST_SR_LOOP: assert property (selfRefresh && $past(selfRefresh) |-> !dllLocked) else $error("loop on");
   AST_RELOCK_MIN: assert property ($rose(dllLocked) |-> lockCnt_q inside {[10'h1f4:10'h208]})
      else $error("relock time wrong");
   AST_RELOCK_MAX: assert property (sSrExit |-> ##[1:600] dllLocked) else $error("no relock");
   AST_SR_HOLD: assert property (sSrHeld |=> selfRefresh) else $error("left self refresh");
   AST_SR_ENTRY: assert property ($rose(selfRefresh) |-> !cke) else $error("entry with enable high");
endmodule // drf_chk
bind drf_dram_core drf_chk u_drf_chk (.clk(clk), .rstn(rstn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cke(cke), .resetN(resetN),
   .rdValid(rdValid), .selfRefresh(selfRefresh), .dllLocked(dllLocked));

// File: testbench/drf_ctrl_model.sv
/*
 memory controller model driving the dram pins.
 assumes the core samples every pin with clk; ck only moves inside pulses.
*/
`timescale 1ns/1ps
module drf_ctrl_model (
   input wire logic clk,
   output logic ck = 1'b0,
   output logic cke = 1'b1,
   output logic csN = 1'b1,
   output logic rasN = 1'b1,
   output logic casN = 1'b1,
   output logic weN = 1'b1,
   output logic resetN = 1'b1,
   output logic termCtrlPin = 1'b1,
   output logic [13:0] addr = 14'h0,
   output logic [2:0] ba = 3'h0,
   output logic [15:0] dq = 16'h0,
   output logic [1:0] writeByteMask = 2'h0
);
   int ivlCnt = 0;
   int nIvl = 0;
   int credit = 0;
   int nRef = 0;
   // one refresh owed per interval
   // no debt grows in self-refresh: the device refreshes itself then
   always @(posedge clk) begin
      if (cke && ivlCnt == drf_pkg::AVG_INTERVAL_CYC - 1) begin
         ivlCnt <= 0;
         nIvl <= nIvl + 1;
      end else if (cke) begin
         ivlCnt <= ivlCnt + 1;
      end
   end
   // pins held round one ck rise
   task automatic pulse(input logic [3:0] c, input logic [13:0] a, input logic [15:0] d, input logic [1:0] m);
      @(posedge clk);
      {csN, rasN, casN, weN} <= c;
      addr <= a;
      dq <= d;
      writeByteMask <= m;
      // eight clk per ck period; pins set three clk before the rise
      repeat (3) @(posedge clk);
      ck <= 1'b1;
      repeat (4) @(posedge clk);
      ck <= 1'b0;
      // released lines must not keep the old value
      {csN, rasN, casN, weN} <= 4'hf;
      addr <= ~a;
      dq <= ~d;
   endtask
   // early refreshes beyond eight earn no credit
   task automatic refresh(input logic [13:0] a);
      pulse(4'h1, a, 16'h0, 2'h0);
      nRef++;
      if (credit - nIvl < 8) credit++;
   endtask
   // termination off, no debt, enable low
   task automatic srEnter();
      while (nIvl - credit > 0) refresh(14'h0);
      @(posedge clk);
      termCtrlPin <= 1'b0;
      repeat (8) @(posedge clk);
      cke <= 1'b0;
      pulse(4'h1, 14'h0, 16'h0, 2'h0);
   endtask
   // exit with no-op, enable kept high
   // calibration advisory; short stay needs none
   task automatic srExit();
      @(posedge clk);
      cke <= 1'b1;
      pulse(4'h7, 14'h0, 16'h0, 2'h0);
   endtask
endmodule // drf_ctrl_model

// File: testbench/drf_dram_core_tb_top.sv
/*
 testbench for the dram command core: ahb register checks, bursts, refresh.
 assumes the controller model owns every dram pin.
*/
`timescale 1ns/1ps
module drf_dram_core_tb_top;
   logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic hreadyout, hresp, ck, cke, csN, rasN, casN, weN, resetN, termCtrlPin, rdValid, selfRefresh, dllLocked;
   logic [31:0] hrdata, v;
   logic [13:0] addr;
   logic [2:0] ba;
   logic [15:0] dq, rdData;
   logic [1:0] writeByteMask;
   logic [15:0] got[$];
   logic [15:0] mem[16];
   int fails = 0, nTests = 0;
   always #10 clk = ~clk;
   always @(posedge clk) if (rdValid === 1'b1) got.push_back(rdData);
   drf_dram_core u_drf_dram_core (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .ck(ck), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
      .resetN(resetN), .termCtrlPin(termCtrlPin), .addr(addr), .ba(ba), .dq(dq),
      .writeByteMask(writeByteMask), .rdData(rdData), .rdValid(rdValid), .selfRefresh(selfRefresh),
      .dllLocked(dllLocked));
   drf_ctrl_model u_m (.clk(clk), .ck(ck), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
      .resetN(resetN), .termCtrlPin(termCtrlPin), .addr(addr), .ba(ba), .dq(dq), .writeByteMask(writeByteMask));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      nTests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      v = hrdata;
   endtask
   task automatic regChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      check("register", exp, v & m);
   endtask
   // mask held high through reads
   task automatic readBurst(input logic [13:0] a, input int c0, input int n, input int p);
      got.delete();
      u_m.pulse(4'h5, a, 16'h0, 2'h3);
      repeat (p) u_m.pulse(4'h7, 14'h0, 16'h0, 2'h3);
      repeat (4) @(posedge clk);
      check("beat count", 32'(n), 32'(got.size()));
      for (int i = 0; i < n; i++) check("read word", {16'h0, mem[c0 + i]}, {16'h0, got[i]});
   endtask
   task automatic printVerdict();
      $display("checks %0d, mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      regChk(drf_pkg::OFS_CTRL, 32'hffffffff, 32'h0);
      regChk(drf_pkg::OFS_STATUS, 32'h0000ff1f, 32'h12);
      regChk(drf_pkg::OFS_REFRESH, 32'hffffffff, 32'h0);
      regChk(8'h0c, 32'hffffffff, 32'h0);
      ahb(1'b1, drf_pkg::OFS_CTRL, 32'h1);
      regChk(drf_pkg::OFS_CTRL, 32'hffffffff, 32'h1);
      ahb(1'b1, drf_pkg::OFS_CTRL, 32'h0);
      ahb(1'b1, drf_pkg::OFS_STATUS, 32'hffffffff);
      regChk(drf_pkg::OFS_STATUS, 32'h0000ff1f, 32'h12);
      u_m.pulse(4'h3, 14'h0, 16'h0, 2'h0);
      regChk(drf_pkg::OFS_STATUS, 32'h0000ff00, 32'h100);
      u_m.pulse(4'h4, 14'h1000, 16'h0, 2'h0);
      for (int i = 0; i < 8; i++) begin
         mem[i] = 16'(16'h1111 * (i + 1));
         u_m.pulse(4'h7, 14'h0, mem[i], 2'h0);
      end
      u_m.pulse(4'h4, 14'h0, 16'h0, 2'h0);
      for (int i = 0; i < 4; i++) begin
         mem[i][15:8] = 8'hff;
         u_m.pulse(4'h7, 14'h0, 16'hffff, 2'h1);
      end
      readBurst(14'h1000, 0, 8, 9);
      readBurst(14'h0004, 4, 4, 6);
      regChk(drf_pkg::OFS_STATUS, 32'h8, 32'h8);
      u_m.pulse(4'h2, 14'h0400, 16'h0, 2'h0);
      regChk(drf_pkg::OFS_STATUS, 32'h0000ff00, 32'h0);
      u_m.refresh(14'h3fff);
      repeat (10) @(posedge clk);
      regChk(drf_pkg::OFS_REFRESH, 32'hffffffff, {16'(u_m.nRef), 3'h0, 13'(u_m.nRef)});
      regChk(drf_pkg::OFS_STATUS, 32'h0000ff04, 32'h0);
      u_m.srEnter();
      u_m.pulse(4'h3, 14'h0, 16'h0, 2'h0);
      repeat (420) @(posedge clk);
      regChk(drf_pkg::OFS_STATUS, 32'h0000ff03, 32'h1);
      // one internal refresh at entry, one a full interval later
      regChk(drf_pkg::OFS_REFRESH, 32'hffff0000, {16'(u_m.nRef + 2), 16'h0});
      u_m.srExit();
      repeat (600) @(posedge clk);
      check("selfRefresh", 32'h0, {31'h0, selfRefresh});
      check("dllLocked", 32'h1, {31'h0, dllLocked});
      u_m.refresh(14'h0);
      repeat (10) @(posedge clk);
      regChk(drf_pkg::OFS_REFRESH, 32'hffff0000, {16'(u_m.nRef + 2), 16'h0});
      printVerdict();
   end
   // whole run is near 28 us; cut off well beyond
   initial begin
      #200000;
      fails++;
      printVerdict();
   end
endmodule // drf_dram_core_tb_top
